// ===== hw/rx_enable_map.vh
// Overview of operation
// - Latch enable high passes enable bus through
// - Enable high keeps channel PLL, analog active
// - Enable low powers channel down
// - Latch enable falling holds last bus value
// - Device reset clears receive enables
// - Self-test latch works alike, independently
// - Active-low fault is OR of four conditions
// - Frequency out of range raises fault
// - Low amplitude raises fault
// - Low transition density raises fault
// - Disabled channel raises fault
// - Self-test bit low compares, high receives
// - In range only within ppm_limit, 1500 ppm at reset
`ifndef RX_ENABLE_MAP_VH
`define RX_ENABLE_MAP_VH
// --------------------------------------------------
// Register map
// --------------------------------------------------
`define REG_INT_STATUS 4'h0
`define REG_INT_MASK 4'h1
`define REG_RX_ENABLE 4'h2
`define REG_SELFTEST 4'h3
`define REG_FAULT 4'h4
`define REG_PPM_LIMIT 4'h5
// --------------------------------------------------
// Field layout and reset values
// --------------------------------------------------
`define NUM_CH 4
`define ST_FAULT_RISE 0
`define ST_FAULT_FALL 4
`define RST_RX_ENABLE 4'h0
`define RST_SELFTEST 4'h0
`define RST_MASK 8'h00
`define PPM_LIMIT 16'h05dc
`endif

// ===== hw/edge_sync.v
`timescale 1ns/100ps
`default_nettype none
// --------------------------------------------------
// Rising and falling edge pulses of a synchronous input
// --------------------------------------------------
module edge_sync (
    input wire clk_sys,
    input wire arst_n,
    input wire level,
    output reg rise,
    output reg fall
);
reg last;
// Previous sample for edge compare
always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
        last <= 1'b0;
        rise <= 1'b0;
        fall <= 1'b0;
    end else begin
        last <= level;
        rise <= level & ~last;
        fall <= ~level & last;
    end
end
endmodule
`default_nettype wire

// ===== hw/transparent_latch.v
`timescale 1ns/100ps
`default_nettype none
// --------------------------------------------------
// Clocked model of a transparent latch
// --------------------------------------------------
module transparent_latch (
    input wire clk_sys,
    input wire arst_n,
    input wire clear,
    input wire open_en,
    input wire [3:0] d,
    output reg [3:0] q
);
// Clear beats open so reset always disables
always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
        q <= 4'h0;
    end else if (clear) begin
        q <= 4'h0;
    end else if (open_en) begin
        q <= d;
    end
end
endmodule
`default_nettype wire

// ===== hw/rx_channel_enable_and_link_fault.v
// Implementation choices: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
`include "rx_enable_map.vh"
module rx_channel_enable_and_link_fault (
    input wire clk_sys,
    input wire arst_n,
    input wire training_clock,
    input wire device_reset_n,
    input wire rx_power_latch_enable,
    input wire selftest_latch_enable,
    input wire [3:0] channel_enable_bus,
    input wire [3:0] amplitude_low,
    input wire [3:0] density_low,
    input wire [63:0] freq_error_ppm,
    input wire [3:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [15:0] reg_rdata,
    output reg [3:0] pll_power_enable,
    output reg [3:0] analog_power_enable,
    output reg [3:0] selftest_compare,
    output reg [3:0] link_fault_n,
    output reg irq
);
// --------------------------------------------------
// Reset sampled on training clock rising edge
// --------------------------------------------------
wire train_rise;
reg reset_seen;
reg reset_n_d;
edge_sync u_train_edge (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .level(training_clock),
    .rise(train_rise),
    .fall()
);
// Reset level delayed one cycle to line up with the edge pulse,
// so the level is the one present as the training clock rose
always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
        reset_n_d <= 1'b1;
        reset_seen <= 1'b0;
    end else begin
        reset_n_d <= device_reset_n;
        reset_seen <= train_rise & ~reset_n_d;
    end
end
// --------------------------------------------------
// Enable latches
// --------------------------------------------------
wire [3:0] rx_latch_q;
wire [3:0] st_latch_q;
// Bit i of bus drives channel i (A..D)
transparent_latch u_rx_latch (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .clear(reset_seen),
    .open_en(rx_power_latch_enable),
    .d(channel_enable_bus),
    .q(rx_latch_q)
);
// Separate latch sharing the same bus
transparent_latch u_st_latch (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .clear(reset_seen),
    .open_en(selftest_latch_enable),
    .d(channel_enable_bus),
    .q(st_latch_q)
);
// --------------------------------------------------
// Frequency window check
// --------------------------------------------------
reg [15:0] ppm_limit;
reg [3:0] freq_bad;
integer i;
// Signed error per channel, 16 bits each
always @* begin
    freq_bad = 4'h0;
    for (i = 0; i < 4; i = i + 1) begin
        if ($signed(freq_error_ppm[i*16 +: 16]) > $signed(ppm_limit) ||
            $signed(freq_error_ppm[i*16 +: 16]) <
            -$signed(ppm_limit)) begin
            freq_bad[i] = 1'b1;
        end
    end
end
// --------------------------------------------------
// Fault combine and outputs
// --------------------------------------------------
wire [3:0] fault;
assign fault = freq_bad | amplitude_low | density_low
    | ~rx_latch_q;
reg [3:0] fault_d;
reg [7:0] int_status;
reg [7:0] int_mask;
wire [7:0] events;
assign events = {fault_d & ~fault, fault & ~fault_d};
// Registered outputs; one cycle of lag
always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
        pll_power_enable <= `RST_RX_ENABLE;
        analog_power_enable <= `RST_RX_ENABLE;
        selftest_compare <= 4'hf;
        link_fault_n <= 4'h0;
        fault_d <= 4'hf;
    end else begin
        pll_power_enable <= rx_latch_q;
        analog_power_enable <= rx_latch_q;
        selftest_compare <= ~st_latch_q;
        link_fault_n <= ~fault;
        fault_d <= fault;
    end
end
// --------------------------------------------------
// Register port and interrupt
// --------------------------------------------------
// Set wins over write-one-to-clear
always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
        int_status <= 8'h00;
        int_mask <= `RST_MASK;
        ppm_limit <= `PPM_LIMIT;
        irq <= 1'b0;
    end else begin
        if (reg_wr && reg_addr == `REG_INT_STATUS) begin
            int_status <= (int_status & ~reg_wdata[7:0]) | events;
        end else begin
            int_status <= int_status | events;
        end
        if (reg_wr && reg_addr == `REG_INT_MASK) begin
            int_mask <= reg_wdata[7:0];
        end
        if (reg_wr && reg_addr == `REG_PPM_LIMIT) begin
            ppm_limit <= reg_wdata;
        end
        irq <= |(int_status & int_mask);
    end
end
// Read data one cycle after strobe, zero otherwise
always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
        reg_rdata <= 16'h0000;
    end else if (!reg_rd) begin
        reg_rdata <= 16'h0000;
    end else if (reg_addr == `REG_INT_STATUS) begin
        reg_rdata <= {8'h00, int_status};
    end else if (reg_addr == `REG_INT_MASK) begin
        reg_rdata <= {8'h00, int_mask};
    end else if (reg_addr == `REG_RX_ENABLE) begin
        reg_rdata <= {12'h000, rx_latch_q};
    end else if (reg_addr == `REG_SELFTEST) begin
        reg_rdata <= {12'h000, st_latch_q};
    end else if (reg_addr == `REG_FAULT) begin
        reg_rdata <= {12'h000, fault};
    end else if (reg_addr == `REG_PPM_LIMIT) begin
        reg_rdata <= ppm_limit;
    end else begin
        reg_rdata <= 16'h0000;
    end
end
endmodule
`default_nettype wire

// ===== test/rx_chk_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module rx_chk (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic training_clock,
    input wire logic device_reset_n,
    input wire logic rx_power_latch_enable,
    input wire logic selftest_latch_enable,
    input wire logic [3:0] channel_enable_bus,
    input wire logic [3:0] amplitude_low,
    input wire logic [3:0] density_low,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic [3:0] pll_power_enable,
    input wire logic [3:0] analog_power_enable,
    input wire logic [3:0] selftest_compare,
    input wire logic [3:0] link_fault_n
);
// ----------------
// Pin rules
// ----------------
default clocking @(posedge clk_sys); endclocking
default disable iff (!arst_n);
a_pass_through: assert property (
    rx_power_latch_enable && device_reset_n |->
    ##2 pll_power_enable == $past(channel_enable_bus, 2)) else $error("pass");
a_hold_value: assert property (
    device_reset_n[*4] ##0 !rx_power_latch_enable |->
    ##2 $stable(pll_power_enable)) else $error("hold");
a_analog_match: assert property (
    analog_power_enable == pll_power_enable) else $error("analog");
a_disabled_fault: assert property (
    (link_fault_n & ~pll_power_enable) == 4'h0) else $error("disabled");
a_amp_fault: assert property (
    (amplitude_low & $past(amplitude_low) & $past(amplitude_low, 2)
    & link_fault_n) == 4'h0) else $error("amplitude");
a_dens_fault: assert property (
    (density_low & $past(density_low) & $past(density_low, 2)
    & link_fault_n) == 4'h0) else $error("density");
a_dev_reset: assert property (
    $rose(training_clock) && !device_reset_n |->
    ##[2:4] pll_power_enable == 4'h0) else $error("device reset");
a_selftest_pass: assert property (
    selftest_latch_enable && device_reset_n |->
    ##2 selftest_compare == ~$past(channel_enable_bus, 2)) else $error("st");
a_rdata_idle: assert property (
    !$past(reg_rd) |-> reg_rdata == 16'h0) else $error("rdata");
// Main scenarios reached
c_latch: cover property (rx_power_latch_enable ##1 !rx_power_latch_enable);
c_fault: cover property (link_fault_n != 4'hf && pll_power_enable == 4'hf);
c_reset: cover property ($rose(training_clock) && !device_reset_n);
endmodule
bind rx_channel_enable_and_link_fault rx_chk rx_chk_inst (.*);
`default_nettype wire

// ===== test/host_model.sv
`timescale 1ns/100ps
`default_nettype none
module host_model (
    input wire logic clk_sys,
    output wire logic training_clock,
    output logic device_reset_n
);
logic [1:0] div = 2'h0;
initial device_reset_n = 1'b1;
// Training clock kept synchronous, quarter rate
always @(posedge clk_sys) div <= div + 2'h1;
assign training_clock = div[1];
// Held low over several rises so it is surely seen
task apply_reset;
    @(posedge clk_sys) device_reset_n <= 1'b0;
    repeat (12) @(posedge clk_sys);
    device_reset_n <= 1'b1;
endtask
endmodule
`default_nettype wire

// ===== test/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
logic clk_sys = 0, arst_n = 0, reg_wr = 0, reg_rd = 0;
logic rx_power_latch_enable = 0, selftest_latch_enable = 0;
logic [3:0] channel_enable_bus = 0, amplitude_low = 0, density_low = 0;
logic [3:0] reg_addr = 0;
logic [63:0] freq_error_ppm = 64'h0;
logic [15:0] reg_wdata = 16'h0;
wire [15:0] reg_rdata;
wire [3:0] pll_power_enable, analog_power_enable;
wire [3:0] selftest_compare, link_fault_n;
wire irq, training_clock, device_reset_n;
int n_errors = 0, n_tests = 0;
logic [3:0] vals[3] = '{4'h5, 4'ha, 4'hf};
host_model host_model_inst (.clk_sys(clk_sys),
    .training_clock(training_clock), .device_reset_n(device_reset_n));
rx_channel_enable_and_link_fault rx_channel_enable_and_link_fault_inst (.*);
initial forever #2 clk_sys = ~clk_sys;
// ----------------
// Access tasks
// ----------------
task chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
        n_errors++;
        $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
endtask
task wt(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
endtask
task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys) reg_wr <= 0;
endtask
task rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk_sys);
    reg_rd <= 1;
    reg_addr <= a;
    @(posedge clk_sys) reg_rd <= 0;
    #1 chk(reg_rdata, e);
endtask
// One cycle of latch enable, then settle
task lat(input bit st, input logic [3:0] v);
    @(posedge clk_sys);
    channel_enable_bus <= v;
    if (st) selftest_latch_enable <= 1;
    else rx_power_latch_enable <= 1;
    @(posedge clk_sys);
    selftest_latch_enable <= 0;
    rx_power_latch_enable <= 0;
    wt(3);
endtask
task finish_test;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
endtask
// Watchdog, far beyond the roughly 150 cycles needed
initial begin
    #200000 n_errors++;
    finish_test;
end
// ----------------
// Tests
// ----------------
initial begin
    wt(10);
    @(posedge clk_sys) arst_n <= 1;
    wt(2);
    chk(pll_power_enable, 0);
    foreach (vals[i]) begin
        lat(0, vals[i]);
        chk(pll_power_enable, vals[i]);
        chk(analog_power_enable, vals[i]);
        @(posedge clk_sys) channel_enable_bus <= ~vals[i];
        wt(3);
        chk(pll_power_enable, vals[i]);
    end
    chk(link_fault_n, 4'hf);
    $display("latch test done");
    for (int i = 0; i < 4; i++) begin
        @(posedge clk_sys) amplitude_low <= 4'h1 << i;
        wt(4);
        chk(link_fault_n, 4'hf ^ (4'h1 << i));
        @(posedge clk_sys) amplitude_low <= 0;
        density_low <= 4'h1 << i;
        wt(4);
        chk(link_fault_n, 4'hf ^ (4'h1 << i));
        @(posedge clk_sys) density_low <= 0;
    end
    // Both edges of the range, signed per channel
    @(posedge clk_sys) freq_error_ppm <= 64'h05dc_fa24_05dd_fa23;
    wt(4);
    chk(link_fault_n, 4'hc);
    wr(4'h1, 16'hff);
    wr(4'h0, 16'hff);
    @(posedge clk_sys) freq_error_ppm <= 64'h0;
    wt(4);
    rd(4'h0, 16'h0030);
    chk(irq, 1);
    wr(4'h1, 16'h0);
    wt(2);
    chk(irq, 0);
    wr(4'h0, 16'h30);
    wr(4'h1, 16'hff);
    wt(2);
    chk(irq, 0);
    $display("fault test done");
    wr(4'h2, 16'h0);
    rd(4'h2, 16'h000f);
    rd(4'h5, 16'h05dc);
    wr(4'h5, 16'h0010);
    rd(4'h5, 16'h0010);
    rd(4'hf, 16'h0);
    lat(0, 4'h6);
    chk(link_fault_n, 4'h6);
    rd(4'h4, 16'h0009);
    lat(1, 4'h3);
    chk(selftest_compare, 4'hc);
    rd(4'h3, 16'h0003);
    chk(pll_power_enable, 4'h6);
    $display("register test done");
    host_model_inst.apply_reset();
    wt(4);
    chk(pll_power_enable, 0);
    chk(selftest_compare, 4'hf);
    $display("reset test done");
    finish_test;
end
endmodule
`default_nettype wire
